// file: hdl/rsia_unit.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - watchdog overflow resets the chip and sets the watchdog status flag
// - any write to the kick address clears watchdog and prescaler high bits
// - twelve-bit prescaler on the oscillator clock; its wrap ticks watchdog
// - watchdog off by test voltage gating, monitor or break cases; it does not tick outside run (stop, wake)
// - illegal instruction sets its status flag and resets the chip
// - stop instruction with stop disabled is an illegal-instruction reset
// - unmapped address resets only on opcode fetch, never on data fetch
// - every internal reset pulls the open-drain reset pin low
// - supply drop sets its flag; holds pin only when both options clear
// - after supply recovers, pin low 4096 plus 32, core free 32 later
// - stop clears prescaler; wake delay 32 if short option, else 4096
// - external pin reset leaves prescaler alone; it runs free afterwards
// - requests latched and arbitrated to a vector code, held until serviced
// - entry tells core to stack registers and set mask; return restores
// - interrupts taken only at instruction end, unmasked and enabled
// - highest priority first; still-pending request taken after return
// - order: reset, software trap, then sources first through last
// - high index register is never stacked on entry
// - software trap ignores mask and stacks pc, hardware stacks pc minus 1
// - pending low register: bits 7..2 are sources 5..0, bits 1..0 zero
// - internal reset stays asserted 32 cycles after the pin is released
module rsia_unit #(parameter int unsigned WD_BITS = 6)
  (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core side
  input wire rsia_pkg::rsia_core_evt_s core_evt,
  output rsia_pkg::rsia_core_cmd_s core_cmd,
  output logic core_reset,
  output logic core_halt,
  // event sources
  input wire logic [15:0] irq_src,
  input wire logic [15:0] irq_enable,
  input wire logic supply_drop,
  input wire logic break_req,
  // test voltage detection
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic hv_on_reset_pin,
  input wire logic hv_on_irq_pin,
  // open-drain reset pin
  input wire logic rst_pin_in_n,
  output logic rst_pin_out_n,
  output logic rst_pin_oe
  );

  localparam int unsigned PB = rsia_pkg::PRESC_BITS;

  rsia_pkg::rsia_state_e state;
  rsia_pkg::rsia_state_e next_state;
  logic [7:0] status;
  logic [7:0] options;
  logic [15:0] pend;
  logic [PB-1:0] presc_cnt;
  logic presc_ovf;
  logic presc_clear;
  logic [WD_BITS-1:0] wd_cnt;
  logic wd_expire;
  logic wd_disable;
  logic kick;
  logic ext_low;
  logic in_run;
  logic illegal_opcode_flag_hit;
  logic illegal_fetch_flag_hit;
  logic lvi_rst;
  logic int_src_hit;
  logic [15:0] req;
  logic lat_swi;

  function automatic logic [4:0] first_set(input logic [15:0] v);
    first_set = rsia_pkg::VEC_IRQ_BASE;
    for (int i = 15; i >= 0; i--)
      if (v[i])
        first_set = rsia_pkg::VEC_IRQ_BASE + 5'(i);
  endfunction

  assign in_run = (state == rsia_pkg::S_RUN);
  assign kick = reg_wr && (reg_addr == rsia_pkg::ADDR_WD_KICK);
  // pin low from outside while this block is not pulling it
  assign ext_low = !rst_pin_in_n && !rst_pin_oe;
  // pure gating of detector levels, so noise cannot latch a disable
  assign wd_disable = (monitor_mode && (hv_on_reset_pin || hv_on_irq_pin))
                      || (break_state && hv_on_reset_pin);
  assign illegal_opcode_flag_hit = core_evt.illegal_opcode
                    || (core_evt.stop_exec
                        && !options[rsia_pkg::OPT_STOP_EN]);
  assign illegal_fetch_flag_hit = core_evt.opcode_fetch && core_evt.fetch_unmapped;
  assign lvi_rst = supply_drop
                   && !options[rsia_pkg::OPT_MON_PWR_OFF]
                   && !options[rsia_pkg::OPT_MON_RST_OFF];
  assign int_src_hit = in_run && (wd_expire || illegal_opcode_flag_hit || illegal_fetch_flag_hit);
  assign req = irq_src & irq_enable;

  rsia_prescaler #(.WIDTH(PB)) u_presc
    (
    .core_clk(core_clk),
    .reset(reset),
    .clear(presc_clear),
    .kick(kick),
    .count(presc_cnt),
    .ovf(presc_ovf)
    );

  // internal reset clears the watchdog; ticks only while running
  rsia_watchdog #(.WD_BITS(WD_BITS)) u_wd
    (
    .core_clk(core_clk),
    .reset(reset),
    .tick(presc_ovf && in_run),
    .clear(kick || core_reset),
    .disable_wd(wd_disable),
    .count(wd_cnt),
    .expire(wd_expire)
    );

  always_comb
  begin
    next_state = state;
    case (state)
      rsia_pkg::S_RUN:
        if (int_src_hit)
          next_state = rsia_pkg::S_PIN;
        else if (core_evt.stop_exec && !ext_low)
          next_state = rsia_pkg::S_STOP;
      rsia_pkg::S_LVI_HOLD:
        if (!supply_drop)
          next_state = rsia_pkg::S_LONG;
      rsia_pkg::S_LONG:
        if (presc_ovf)
          next_state = rsia_pkg::S_PIN;
      rsia_pkg::S_PIN:
        if (rsia_pkg::phase_done(presc_cnt, rsia_pkg::SHORT_CYCLES))
          next_state = rsia_pkg::S_TAIL;
      rsia_pkg::S_TAIL:
        if (rsia_pkg::phase_done(presc_cnt, rsia_pkg::SHORT_CYCLES))
          next_state = rsia_pkg::S_RUN;
      rsia_pkg::S_STOP:
        if ((|req) || break_req || ext_low)
          next_state = rsia_pkg::S_WAKE;
      rsia_pkg::S_WAKE:
        if (rsia_pkg::phase_done(presc_cnt,
              options[rsia_pkg::OPT_SHORT_WAKE] ? rsia_pkg::SHORT_CYCLES
                                                : rsia_pkg::LONG_CYCLES))
          next_state = rsia_pkg::S_RUN;
      default:
        next_state = rsia_pkg::S_RUN;
    endcase
    // a supply drop with both options clear overrides every other sequence
    if (lvi_rst)
      next_state = rsia_pkg::S_LVI_HOLD;
  end

  // counter restarts at each reset phase and is held through stop;
  // nothing here reacts to the external pin, so its count survives
  assign presc_clear = (state == rsia_pkg::S_STOP)
    || (state == rsia_pkg::S_LVI_HOLD)
    || ((next_state != state) && ((next_state == rsia_pkg::S_PIN)
        || (next_state == rsia_pkg::S_TAIL)));

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state <= rsia_pkg::S_LONG; // power-up runs the long hold
    else
      state <= next_state;
  end

  // pin and core reset straight from flops
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rst_pin_oe <= 1'b1;
      rst_pin_out_n <= 1'b0;
      core_reset <= 1'b1;
      core_halt <= 1'b0;
    end
    else
    begin
      rst_pin_oe <= (next_state == rsia_pkg::S_LVI_HOLD)
                    || (next_state == rsia_pkg::S_LONG)
                    || (next_state == rsia_pkg::S_PIN);
      rst_pin_out_n <= 1'b0;
      core_reset <= ext_low || !((next_state == rsia_pkg::S_RUN)
                    || (next_state == rsia_pkg::S_STOP)
                    || (next_state == rsia_pkg::S_WAKE));
      core_halt <= (next_state == rsia_pkg::S_STOP)
                   || (next_state == rsia_pkg::S_WAKE);
    end
  end

  // reset source status: read clears, a same-cycle set still lands
  always_ff @(posedge core_clk)
  begin
    if (reset)
      status <= rsia_pkg::STATUS_RESET;
    else
    begin
      if (reg_rd && (reg_addr == rsia_pkg::ADDR_STATUS))
        status <= '0;
      if (in_run && wd_expire)
        status[rsia_pkg::ST_WD] <= 1'b1;
      if (in_run && illegal_opcode_flag_hit)
        status[rsia_pkg::ST_ILLEGAL_OPCODE_FLAG] <= 1'b1;
      if (in_run && illegal_fetch_flag_hit)
        status[rsia_pkg::ST_ILLEGAL_FETCH_FLAG] <= 1'b1;
      if (supply_drop)
        status[rsia_pkg::ST_LVI] <= 1'b1;
      if (ext_low && in_run && !int_src_hit && !supply_drop)
        status[rsia_pkg::ST_PIN] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      options <= rsia_pkg::OPTIONS_RESET;
    else if (reg_wr && (reg_addr == rsia_pkg::ADDR_OPTIONS))
      options <= reg_wdata & rsia_pkg::OPTIONS_MASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      pend <= '0;
    else
      pend <= irq_src;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else
      case (reg_addr)
        rsia_pkg::ADDR_STATUS: reg_rdata <= status;
        rsia_pkg::ADDR_PEND_LOW: reg_rdata <= {pend[5:0], 2'b00};
        rsia_pkg::ADDR_PEND_MID: reg_rdata <= pend[13:6];
        rsia_pkg::ADDR_PEND_HIGH: reg_rdata <= {6'b00_0000, pend[15:14]};
        rsia_pkg::ADDR_OPTIONS: reg_rdata <= options;
        default: reg_rdata <= '0;
      endcase
  end

  // interrupt latch and core entry commands
  always_ff @(posedge core_clk)
  begin
    if (reset || core_reset)
    begin
      core_cmd <= '0;
      core_cmd.vector <= rsia_pkg::VEC_RESET;
      lat_swi <= 1'b0;
    end
    else
    begin
      core_cmd.set_mask <= 1'b0;
      core_cmd.push_pc_dec <= 1'b0;
      core_cmd.push_index_high <= 1'b0;
      core_cmd.restore_regs <= core_evt.rti_exec;
      if (core_cmd.int_req && core_evt.int_ack)
      begin
        core_cmd.int_req <= 1'b0;
        core_cmd.set_mask <= 1'b1;
        core_cmd.push_pc_dec <= !lat_swi;
      end
      // boundary only; a return is itself a boundary
      else if (!core_cmd.int_req && core_evt.instr_end && in_run)
      begin
        if (core_evt.swi_exec)
        begin
          core_cmd.int_req <= 1'b1;
          core_cmd.vector <= rsia_pkg::VEC_SWI;
          lat_swi <= 1'b1;
        end
        else if (!core_evt.i_mask && (|req))
        begin
          core_cmd.int_req <= 1'b1;
          core_cmd.vector <= first_set(req);
          lat_swi <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  property p_wd_reset;
    in_run && wd_expire && !lvi_rst |=> state == rsia_pkg::S_PIN
      && status[rsia_pkg::ST_WD] ##1 rst_pin_oe;
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("watchdog expiry did not start a reset");

  property p_kick;
    kick && !presc_clear |=> presc_cnt[PB-1:rsia_pkg::KICK_CLR_LSB] == '0
      && wd_cnt == '0;
  endproperty
  a_kick: assert property (p_kick)
    else $error("kick did not clear counters");

  property p_ovf;
    presc_ovf |-> presc_cnt == {PB{1'b1}} ##1 presc_cnt == '0;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("prescaler overflow at wrong count");

  property p_wd_off;
    wd_disable |-> !wd_expire ##1 $stable(wd_cnt) || core_reset;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog moved while disabled");

  property p_illegal_opcode_flag;
    in_run && illegal_opcode_flag_hit && !lvi_rst |=> status[rsia_pkg::ST_ILLEGAL_OPCODE_FLAG]
      && state == rsia_pkg::S_PIN;
  endproperty
  a_illegal_opcode_flag: assert property (p_illegal_opcode_flag)
    else $error("illegal opcode not reset");

  property p_stop_illegal;
    in_run && core_evt.stop_exec && !options[rsia_pkg::OPT_STOP_EN]
      && !lvi_rst |=> state == rsia_pkg::S_PIN;
  endproperty
  a_stop_illegal: assert property (p_stop_illegal)
    else $error("disabled stop not treated as illegal");

  property p_data_fetch;
    in_run && core_evt.fetch_unmapped && !core_evt.opcode_fetch
      && !illegal_opcode_flag_hit && !wd_expire && !lvi_rst && !core_evt.stop_exec
      |=> state == rsia_pkg::S_RUN;
  endproperty
  a_data_fetch: assert property (p_data_fetch)
    else $error("data fetch caused a reset");

  property p_pin;
    state == rsia_pkg::S_PIN |-> rst_pin_oe && !rst_pin_out_n;
  endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin not driven low");

  property p_lvi_hold;
    lvi_rst |=> state == rsia_pkg::S_LVI_HOLD ##1 rst_pin_oe;
  endproperty
  a_lvi_hold: assert property (p_lvi_hold)
    else $error("supply drop did not hold pin");

  sequence s_pin_released;
    state == rsia_pkg::S_TAIL && $past(state) == rsia_pkg::S_PIN;
  endsequence
  sequence s_tail_held;
    core_reset && !rst_pin_oe;
  endsequence
  property p_tail;
    s_pin_released and (!lvi_rst && !$past(lvi_rst))
      |-> s_tail_held [*8] ##25 state == rsia_pkg::S_RUN;
  endproperty
  a_tail: assert property (p_tail)
    else $error("core reset tail is not 32 cycles");

  property p_long;
    state == rsia_pkg::S_LONG && presc_ovf && !lvi_rst
      |=> state == rsia_pkg::S_PIN ##1 rst_pin_oe;
  endproperty
  a_long: assert property (p_long)
    else $error("long hold did not run into pin phase");

  property p_latched;
    core_cmd.int_req && !core_evt.int_ack && !core_reset
      |=> core_cmd.int_req && $stable(core_cmd.vector);
  endproperty
  a_latched: assert property (p_latched)
    else $error("latched request was preempted");

  property p_entry;
    core_cmd.int_req && core_evt.int_ack && !core_reset
      |=> core_cmd.set_mask && !core_cmd.push_index_high
      && core_cmd.push_pc_dec == !$past(lat_swi);
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry commands wrong");

  property p_masked;
    !core_cmd.int_req && (core_evt.i_mask || !core_evt.instr_end)
      && !core_evt.swi_exec |=> !core_cmd.int_req;
  endproperty
  a_masked: assert property (p_masked)
    else $error("interrupt taken while masked or mid instruction");

endmodule

// file: hdl/rsia_pkg.sv
package rsia_pkg;

  // register map
  localparam logic [15:0] ADDR_STATUS = 16'hfe01;
  localparam logic [15:0] ADDR_PEND_LOW = 16'hfe04;
  localparam logic [15:0] ADDR_PEND_MID = 16'hfe05;
  localparam logic [15:0] ADDR_PEND_HIGH = 16'hfe06;
  localparam logic [15:0] ADDR_OPTIONS = 16'hfe10;
  localparam logic [15:0] ADDR_WD_KICK = 16'hffff;

  // reset source status bits
  localparam int unsigned ST_POR = 7;
  localparam int unsigned ST_PIN = 6;
  localparam int unsigned ST_WD = 5;
  localparam int unsigned ST_ILLEGAL_OPCODE_FLAG = 4;
  localparam int unsigned ST_ILLEGAL_FETCH_FLAG = 3;
  localparam int unsigned ST_LVI = 1;
  localparam logic [7:0] STATUS_RESET = 8'h80;

  // option bits
  localparam int unsigned OPT_STOP_EN = 0;
  localparam int unsigned OPT_SHORT_WAKE = 1;
  localparam int unsigned OPT_MON_PWR_OFF = 2;
  localparam int unsigned OPT_MON_RST_OFF = 3;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_MASK = 8'h0f;

  // prescaler and reset timing, in oscillator cycles
  localparam int unsigned PRESC_BITS = 12;
  localparam int unsigned KICK_CLR_LSB = 5;
  localparam int unsigned LONG_CYCLES = 4096;
  localparam int unsigned SHORT_CYCLES = 32;

  // vector select codes
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_SWI = 5'h01;
  localparam logic [4:0] VEC_IRQ_BASE = 5'h02;

  typedef enum logic [2:0] {
    S_RUN, S_LVI_HOLD, S_LONG, S_PIN, S_TAIL, S_STOP, S_WAKE
  } rsia_state_e;

  typedef struct packed {
    logic instr_end;
    logic i_mask;
    logic illegal_opcode;
    logic stop_exec;
    logic swi_exec;
    logic rti_exec;
    logic opcode_fetch;
    logic fetch_unmapped;
    logic int_ack;
  } rsia_core_evt_s;

  typedef struct packed {
    logic int_req;
    logic [4:0] vector;
    logic set_mask;
    logic push_pc_dec;
    logic push_index_high;
    logic restore_regs;
  } rsia_core_cmd_s;

  function automatic logic phase_done(input logic [PRESC_BITS-1:0] cnt,
                                      input int unsigned len);
    phase_done = (cnt == PRESC_BITS'(len - 1));
  endfunction

endpackage

// file: hdl/rsia_prescaler.sv
`timescale 1ns/1ps
module rsia_prescaler #(parameter int unsigned WIDTH = rsia_pkg::PRESC_BITS)
  (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic clear,
  input wire logic kick,
  // state
  output logic [WIDTH-1:0] count,
  output logic ovf
  );

  localparam logic [WIDTH-1:0] KEEP_LOW =
    WIDTH'((1 << rsia_pkg::KICK_CLR_LSB) - 1);

  always_ff @(posedge core_clk)
  begin
    if (reset || clear)
      count <= '0;
    else if (kick)
      count <= count & KEEP_LOW;
    else
      count <= count + 1'b1;
  end

  // wrap of the full count clocks the watchdog; clear is left out so
  // the state decode that drives clear cannot loop back through ovf
  assign ovf = (&count) && !kick;

endmodule

// file: hdl/rsia_watchdog.sv
`timescale 1ns/1ps
module rsia_watchdog #(parameter int unsigned WD_BITS = 6)
  (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // control
  input wire logic tick,
  input wire logic clear,
  input wire logic disable_wd,
  // state
  output logic [WD_BITS-1:0] count,
  output logic expire
  );

  always_ff @(posedge core_clk)
  begin
    if (reset || clear)
      count <= '0;
    else if (tick && !disable_wd)
      count <= count + 1'b1;
  end

  assign expire = tick && (&count) && !disable_wd && !clear;

endmodule

// file: sim/rsia_core_model.sv
`timescale 1ns/1ps
module rsia_core_model
  (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // bench requests: mask level, trap and fault events
  input wire rsia_pkg::rsia_core_evt_s evt_in,
  // design side
  input wire rsia_pkg::rsia_core_cmd_s core_cmd,
  input wire logic core_reset,
  input wire logic core_halt,
  output rsia_pkg::rsia_core_evt_s core_evt
  );
  logic [1:0] step = 2'h0;
  logic [3:0] isr = 4'h0;
  logic bnd = 1'b0;
  logic ack = 1'b0;
  logic req_d = 1'b0;
  logic return_from_trap = 1'b0;
  logic swi_p = 1'b0;
  // no boundary while a vector waits or stacking is under way
  always_ff @(posedge core_clk)
  begin
    step <= step + 2'h1;
    bnd <= !reset && !core_reset && !core_halt && !ack
      && (step == 2'h3 || isr == 4'h8) && !core_cmd.int_req
      && !core_cmd.set_mask;
  end
  // vector taken two cycles after it is raised
  always_ff @(posedge core_clk)
  begin
    req_d <= core_cmd.int_req && !reset;
    ack <= core_cmd.int_req && req_d && !ack && !reset;
  end
  // mask held by the core for a short service routine, then return
  always_ff @(posedge core_clk)
  begin
    return_from_trap <= isr == 4'h8 && !reset && !core_reset;
    if (reset || core_reset)
      isr <= 4'h0;
    else if (core_cmd.set_mask)
      isr <= 4'h1;
    else if (isr == 4'h8)
      isr <= 4'h0;
    else if (isr != 4'h0)
      isr <= isr + 4'h1;
  end
  always_ff @(posedge core_clk)
  begin
    swi_p <= !reset && (evt_in.swi_exec || (swi_p && !bnd));
  end
  assign core_evt = {bnd, evt_in.i_mask | (isr != 4'h0),
    evt_in.illegal_opcode, evt_in.stop_exec, bnd & swi_p, return_from_trap,
    evt_in.opcode_fetch, evt_in.fetch_unmapped, ack};
endmodule

// file: sim/rsia_unit_tb_top.sv
`timescale 1ns/1ps
module rsia_unit_tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  rsia_pkg::rsia_core_evt_s evt_in;
  rsia_pkg::rsia_core_evt_s core_evt;
  rsia_pkg::rsia_core_evt_s ev;
  rsia_pkg::rsia_core_cmd_s core_cmd;
  logic core_reset;
  logic core_halt;
  logic [15:0] irq_src = 16'h0000;
  logic [15:0] irq_enable = 16'hffff;
  logic supply_drop = 1'b0;
  logic break_req = 1'b0;
  logic monitor_mode = 1'b0;
  logic hv_rst = 1'b0;
  logic rst_pin_out_n;
  logic rst_pin_oe;
  // pull-up on the reset pin
  wire pin_n = !(rst_pin_oe && !rst_pin_out_n);
  int n_fail = 0;
  int checked = 0;
  int n;
  logic [7:0] d;

  rsia_unit #(.WD_BITS(2)) dut (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_evt(core_evt),
    .core_cmd(core_cmd), .core_reset(core_reset), .core_halt(core_halt),
    .irq_src(irq_src), .irq_enable(irq_enable), .supply_drop(supply_drop),
    .break_req(break_req), .monitor_mode(monitor_mode),
    .break_state(1'b0), .hv_on_reset_pin(hv_rst), .hv_on_irq_pin(1'b0),
    .rst_pin_in_n(pin_n), .rst_pin_out_n(rst_pin_out_n),
    .rst_pin_oe(rst_pin_oe));
  rsia_core_model core (.core_clk(core_clk), .reset(reset),
    .evt_in(evt_in), .core_cmd(core_cmd), .core_reset(core_reset),
    .core_halt(core_halt), .core_evt(core_evt));

  always #20 core_clk = ~core_clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rng(input string s, input int lo, input int hi,
                     input int g);
    chk(s, 16'h0001, {15'h0000, g >= lo && g <= hi});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    chk("reg_rdata", e, d);
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: cond = core_reset === 1'b0;
      1: cond = rst_pin_oe === 1'b0;
      2: cond = core_cmd.int_req === 1'b1;
      3: cond = core_halt === 1'b0;
      4: cond = core_reset === 1'b1;
      5: cond = core_cmd.set_mask === 1'b1;
      default: cond = core_cmd.restore_regs === 1'b1;
    endcase
  endfunction
  task automatic wait_for(input int w, input int lim, output int k);
    k = 0;
    while (!cond(w))
    begin
      @(posedge core_clk);
      #1;
      k++;
      if (k > lim)
      begin
        n_fail++;
        $display("mismatch wait %0d expected done seen timeout", w);
        close_out;
      end
    end
  endtask
  // one-cycle core event, mask level kept
  task automatic pulse(input rsia_pkg::rsia_core_evt_s e);
    logic m;
    m = evt_in.i_mask;
    e.i_mask = m;
    @(posedge core_clk);
    evt_in <= e;
    e = '0;
    e.i_mask = m;
    @(posedge core_clk);
    evt_in <= e;
    #1;
  endtask
  task automatic irst(input rsia_pkg::rsia_core_evt_s e, input int b);
    pulse(e);
    chk("rst_pin_oe", 1, rst_pin_oe);
    chk("rst_pin_out_n", 0, rst_pin_out_n);
    wait_for(1, 100, n);
    chk("pin_cycles", 32, n);
    wait_for(0, 100, n);
    chk("tail_cycles", 32, n);
    rdc(rsia_pkg::ADDR_STATUS, 8'(1 << b));
  endtask

  initial
  begin
    evt_in = '0;
    evt_in.i_mask = 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    wait_for(1, 5000, n);
    rng("por_hold", 4127, 4131, n);
    wait_for(0, 100, n);
    chk("por_tail", 32, n);
    rdc(rsia_pkg::ADDR_STATUS, rsia_pkg::STATUS_RESET);
    rdc(rsia_pkg::ADDR_STATUS, 8'h00);
    rdc(rsia_pkg::ADDR_PEND_LOW, 8'h00);
    wr(rsia_pkg::ADDR_WD_KICK, 8'h00);
    @(posedge core_clk);
    irq_src <= 16'hc07f;
    tick(2);
    rdc(rsia_pkg::ADDR_PEND_LOW, 8'hfc);
    wr(rsia_pkg::ADDR_PEND_LOW, 8'h00);
    rdc(rsia_pkg::ADDR_PEND_LOW, 8'hfc);
    rdc(rsia_pkg::ADDR_PEND_MID, 8'h01);
    rdc(rsia_pkg::ADDR_PEND_HIGH, 8'h03);
    rdc(16'hfe02, 8'h00);
    chk("int_req_masked", 0, core_cmd.int_req);
    @(posedge core_clk);
    irq_enable <= 16'h0000;
    evt_in.i_mask <= 1'b0;
    tick(12);
    chk("int_req_disabled", 0, core_cmd.int_req);
    @(posedge core_clk);
    irq_src <= 16'h0024;
    irq_enable <= 16'hffff;
    wait_for(2, 20, n);
    chk("vector", rsia_pkg::VEC_IRQ_BASE + 5'h02, core_cmd.vector);
    @(posedge core_clk);
    irq_src <= 16'h0025;
    #1;
    chk("vector_held", rsia_pkg::VEC_IRQ_BASE + 5'h02,
        core_cmd.vector);
    wait_for(5, 20, n);
    chk("push_pc_dec", 1, core_cmd.push_pc_dec);
    chk("push_index_high", 0, core_cmd.push_index_high);
    wait_for(6, 20, n);
    chk("restore_regs", 1, core_cmd.restore_regs);
    wait_for(2, 20, n);
    chk("vector_next", rsia_pkg::VEC_IRQ_BASE, core_cmd.vector);
    @(posedge core_clk);
    irq_src <= 16'h0000;
    evt_in.i_mask <= 1'b1;
    wait_for(6, 40, n);
    ev = '0;
    ev.swi_exec = 1'b1;
    pulse(ev);
    wait_for(2, 20, n);
    chk("vector_trap", rsia_pkg::VEC_SWI, core_cmd.vector);
    wait_for(5, 20, n);
    chk("push_pc_trap", 0, core_cmd.push_pc_dec);
    wait_for(6, 40, n);
    ev = '0;
    ev.illegal_opcode = 1'b1;
    irst(ev, rsia_pkg::ST_ILLEGAL_OPCODE_FLAG);
    ev = '0;
    ev.stop_exec = 1'b1;
    irst(ev, rsia_pkg::ST_ILLEGAL_OPCODE_FLAG);
    ev = '0;
    ev.opcode_fetch = 1'b1;
    ev.fetch_unmapped = 1'b1;
    irst(ev, rsia_pkg::ST_ILLEGAL_FETCH_FLAG);
    ev = '0;
    ev.fetch_unmapped = 1'b1;
    pulse(ev);
    tick(3);
    chk("data_fetch_oe", 0, rst_pin_oe);
    repeat (7)
    begin
      wr(rsia_pkg::ADDR_WD_KICK, 8'h5a);
      tick(2900);
    end
    rdc(rsia_pkg::ADDR_STATUS, 8'h00);
    @(posedge core_clk);
    monitor_mode <= 1'b1;
    hv_rst <= 1'b1;
    tick(20000);
    rdc(rsia_pkg::ADDR_STATUS, 8'h00);
    wr(rsia_pkg::ADDR_WD_KICK, 8'h00);
    @(posedge core_clk);
    monitor_mode <= 1'b0;
    hv_rst <= 1'b0;
    #1;
    wait_for(4, 20000, n);
    rng("wd_period", 12200, 16450, n);
    wait_for(0, 200, n);
    rdc(rsia_pkg::ADDR_STATUS, 8'(1 << rsia_pkg::ST_WD));
    @(posedge core_clk);
    supply_drop <= 1'b1;
    tick(10);
    chk("drop_oe", 1, rst_pin_oe);
    @(posedge core_clk);
    supply_drop <= 1'b0;
    #1;
    wait_for(1, 5000, n);
    rng("drop_hold", 4127, 4131, n);
    wait_for(0, 100, n);
    chk("drop_tail", 32, n);
    rdc(rsia_pkg::ADDR_STATUS, 8'(1 << rsia_pkg::ST_LVI));
    wr(rsia_pkg::ADDR_OPTIONS, 8'h04);
    rdc(rsia_pkg::ADDR_OPTIONS, 8'h04);
    @(posedge core_clk);
    supply_drop <= 1'b1;
    tick(10);
    chk("drop_oe_off", 0, rst_pin_oe);
    @(posedge core_clk);
    supply_drop <= 1'b0;
    tick(2);
    rdc(rsia_pkg::ADDR_STATUS, 8'(1 << rsia_pkg::ST_LVI));
    for (int s = 0; s < 2; s++)
    begin
      wr(rsia_pkg::ADDR_OPTIONS, s ? 8'h03 : 8'h01);
      ev = '0;
      ev.stop_exec = 1'b1;
      pulse(ev);
      tick(3);
      chk("halt", 1, core_halt);
      @(posedge core_clk);
      break_req <= 1'b1;
      #1;
      wait_for(3, 5000, n);
      @(posedge core_clk);
      break_req <= 1'b0;
      rng("wake_delay", s ? 32 : 4096, s ? 35 : 4099, n);
    end
    close_out;
  end
endmodule
